/* rtl/gsp_pwm_driver.sv */
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "gsp_regs.svh"
// Overview of operation
// - one shared 12-bit counter advances only on reference clock rising edges
// - blanking high forces and holds the counter at zero
// - after blanking falls the counter counts each reference rising edge up to all ones, then holds
// - nonzero channels turn on at the first reference edge after blanking
// - channel on while counter at most its value, off once above
// - blanking high holds all sixteen sink outputs off
// - sink current is the 6-bit correction code, zero to full scale
// - after a strobe, first shift edge with select low loads snapshot
// - open bits from 33rd reference edge; thermal bits at that shift edge
// - an on output with low voltage is forced off automatically
// - grayscale registers have no trusted power-up contents; host loads first
// - correction registers have no trusted power-up contents; host loads first
// - 192-bit grayscale shift and latch, msb first, select low
// - 96-bit correction shift and latch, used while select high
// - snapshot overwrites only the top 18 grayscale shift bits
// - an open-led snapshot bit reads one for a channel open while on at the 33rd edge
module gsp_pwm_driver (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// serial link pins
	input wire logic serial_input_i,
	input wire logic shift_clock_i,
	input wire logic latch_strobe_i,
	input wire logic correction_select_i,
	input wire logic blank_i,
	input wire logic pwm_reference_clock_i,
	output logic serial_output_o,
	// analog sense inputs
	input wire gsp_pkg::gsp_chan_t open_detect_i,
	input wire logic overheat_flag_i,
	input wire logic heat_warning_flag_i,
	// sink outputs
	output gsp_pkg::gsp_chan_t sink_output_n_o,
	output gsp_pkg::gsp_level_t sink_current_o,
	// open-drain error pin, enable low drives low
	output logic error_indicator_pin_o,
	output logic error_indicator_pin_oe_n_o,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire gsp_pkg::gsp_addr_t wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire gsp_pkg::gsp_word_t wb_dat_i,
	output gsp_pkg::gsp_word_t wb_dat_o,
	output logic wb_ack_o,
	// interrupt
	output logic irq_o
);
	import gsp_pkg::*;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	localparam int PIN_W = 24;
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s1_reg;
	logic [PIN_W-1:0] pin_s2_reg;
	logic [PIN_W-1:0] pin_s3_reg;
	logic sin_s, sclk_s, strobe_s, correction_select_s, blank_s, ovh_s, warn_s;
	gsp_chan_t open_s;
	logic sclk_rise, strobe_rise, strobe_fall, gs_rise;
	assign pin_raw = {heat_warning_flag_i, overheat_flag_i, open_detect_i, pwm_reference_clock_i,
		blank_i, correction_select_i, latch_strobe_i, shift_clock_i, serial_input_i};
	// s1 feeds only s2; s3 is the previous s2 for edge finding
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end
	assign sin_s = pin_s2_reg[0];
	assign sclk_s = pin_s2_reg[1];
	assign strobe_s = pin_s2_reg[2];
	assign correction_select_s = pin_s2_reg[3];
	assign blank_s = pin_s2_reg[4];
	assign open_s = pin_s2_reg[21:6];
	assign ovh_s = pin_s2_reg[22];
	assign warn_s = pin_s2_reg[23];
	assign sclk_rise = sclk_s & ~pin_s3_reg[1];
	assign strobe_rise = strobe_s & ~pin_s3_reg[2];
	assign strobe_fall = ~strobe_s & pin_s3_reg[2];
	assign gs_rise = pin_s2_reg[5] & ~pin_s3_reg[5];

	// ************************************************************
	// grayscale counter
	// ************************************************************
	gsp_count_t cnt_reg;
	// saturation keeps outputs from restarting inside one period
	always_ff @(posedge clk_i) begin
		if (rst_i || blank_s) begin
			cnt_reg <= '0;
		end else if (gs_rise && cnt_reg != `GSP_CNT_MAX) begin
			cnt_reg <= cnt_reg + `GSP_CNT_ONE;
		end
	end

	// ************************************************************
	// shift registers and latches
	// ************************************************************
	logic [`GSP_GS_SR_W-1:0] gs_sr_reg;
	logic [`GSP_GS_SR_W-1:0] gs_lat_reg;
	logic [`GSP_DC_SR_W-1:0] dc_sr_reg;
	logic [`GSP_DC_SR_W-1:0] dc_lat_reg;
	logic snap_pend_reg;
	gsp_chan_t lod_saved_reg;
	logic [`GSP_SNAP_W-1:0] snapshot;
	// both thermal bits are the live synced overheat flag at the loading edge
	assign snapshot = {ovh_s, ovh_s, lod_saved_reg};
	// snapshot pending from strobe fall until a select-low shift edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			snap_pend_reg <= 1'b0;
		end else if (strobe_fall) begin
			snap_pend_reg <= 1'b1;
		end else if (sclk_rise && !correction_select_s) begin
			snap_pend_reg <= 1'b0;
		end
	end
	// grayscale shift path; the loading edge replaces the shift
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gs_sr_reg <= '0;
		end else if (sclk_rise && !correction_select_s) begin
			if (snap_pend_reg) begin
				gs_sr_reg[`GSP_GS_SR_W-1:`GSP_SNAP_LSB] <= snapshot;
			end else begin
				gs_sr_reg <= {gs_sr_reg[`GSP_GS_SR_W-2:0], sin_s};
			end
		end
	end
	// correction shift path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dc_sr_reg <= '0;
		end else if (sclk_rise && correction_select_s) begin
			dc_sr_reg <= {dc_sr_reg[`GSP_DC_SR_W-2:0], sin_s};
		end
	end
	// latches clear at reset, but the host must still load both
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gs_lat_reg <= '0;
			dc_lat_reg <= '0;
		end else if (strobe_rise) begin
			if (correction_select_s) begin
				dc_lat_reg <= dc_sr_reg;
			end else begin
				gs_lat_reg <= gs_sr_reg;
			end
		end
	end
	// serial output follows the msb of the selected register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_output_o <= 1'b0;
		end else begin
			serial_output_o <= correction_select_s ? dc_sr_reg[`GSP_DC_SR_W-1] : gs_sr_reg[`GSP_GS_SR_W-1];
		end
	end

	// ************************************************************
	// channel comparators and drivers
	// ************************************************************
	logic force_off_reg;
	gsp_chan_t auto_off_reg;
	gsp_chan_t ch_on;
	for (genvar i = 0; i < `GSP_CH_N; i++) begin : g_ch
		// own compare per channel against the shared counter
		assign ch_on[i] = !blank_s && !force_off_reg && !ovh_s && !auto_off_reg[i]
			&& cnt_reg != '0 && cnt_reg <= gs_lat_reg[i*12 +: 12];
		// a low output voltage while on latches the channel off
		always_ff @(posedge clk_i) begin
			if (rst_i || blank_s) begin
				auto_off_reg[i] <= 1'b0;
			end else if (sink_output_n_o[i] && open_s[i]) begin
				auto_off_reg[i] <= 1'b1;
			end
		end
		// current magnitude is the correction code while on
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				sink_output_n_o[i] <= 1'b0;
				sink_current_o[i*6 +: 6] <= '0;
			end else begin
				sink_output_n_o[i] <= ch_on[i];
				sink_current_o[i*6 +: 6] <= ch_on[i] ? dc_lat_reg[i*6 +: 6] : 6'h00;
			end
		end
	end
	// open results only count for outputs on at the 33rd edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lod_saved_reg <= '0;
		end else if (gs_rise && !blank_s && cnt_reg == `GSP_LOD_SAMPLE_CNT - `GSP_CNT_ONE) begin
			lod_saved_reg <= sink_output_n_o & open_s;
		end
	end
	// error pin pulls low on any open result or overheat
	assign error_indicator_pin_o = 1'b0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			error_indicator_pin_oe_n_o <= 1'b1;
		end else begin
			error_indicator_pin_oe_n_o <= !(ovh_s || (|lod_saved_reg));
		end
	end

	// ************************************************************
	// events and interrupt
	// ************************************************************
	gsp_event_t status_reg, mask_reg, ev_set, ev_clr;
	logic ovh_d_reg, warn_d_reg;
	logic bus_req, wr_stb;
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_stb = bus_req && wb_we_i;
	// previous thermal levels for rise detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovh_d_reg <= 1'b0;
			warn_d_reg <= 1'b0;
		end else begin
			ovh_d_reg <= ovh_s;
			warn_d_reg <= warn_s;
		end
	end
	// event strobes and the write-one clear mask
	always_comb begin
		ev_set = '0;
		ev_set[`GSP_EV_LOD] = gs_rise && !blank_s
			&& cnt_reg == `GSP_LOD_SAMPLE_CNT - `GSP_CNT_ONE && |(sink_output_n_o & open_s);
		ev_set[`GSP_EV_OVERHEAT] = ovh_s && !ovh_d_reg;
		ev_set[`GSP_EV_SNAP] = snap_pend_reg && sclk_rise && !correction_select_s;
		ev_set[`GSP_EV_WARN] = warn_s && !warn_d_reg;
		ev_clr = (wr_stb && wb_adr_i == `GSP_ADR_STATUS && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;
	end
	// set beats a same-cycle write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= '0;
		end else begin
			status_reg <= (status_reg & ~ev_clr) | ev_set;
		end
	end
	// level interrupt from unmasked sticky bits
	assign irq_o = |(status_reg & mask_reg);

	// ************************************************************
	// wishbone slave
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			force_off_reg <= `GSP_RST_CTRL;
			mask_reg <= `GSP_RST_MASK;
		end else if (wr_stb && wb_sel_i[0]) begin
			if (wb_adr_i == `GSP_ADR_CTRL) begin
				force_off_reg <= wb_dat_i[`GSP_CTRL_FORCE_OFF];
			end
			if (wb_adr_i == `GSP_ADR_MASK) begin
				mask_reg <= wb_dat_i[3:0];
			end
		end
	end
	// one wait state; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req;
			case (wb_adr_i)
				`GSP_ADR_CTRL: wb_dat_o <= {31'h0, force_off_reg};
				`GSP_ADR_STATUS: wb_dat_o <= {28'h0, status_reg};
				`GSP_ADR_MASK: wb_dat_o <= {28'h0, mask_reg};
				`GSP_ADR_COUNT: wb_dat_o <= {20'h0, cnt_reg};
				`GSP_ADR_SNAP: wb_dat_o <= {14'h0, snapshot};
				default: wb_dat_o <= 32'h0;
			endcase
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_blank_zero;
		blank_s |=> cnt_reg == '0;
	endproperty
	a_blank_zero: assert property (p_blank_zero) else $error("counter not zero in blank");
	property p_count_step;
		(!blank_s && gs_rise && cnt_reg != `GSP_CNT_MAX) |=> cnt_reg == $past(cnt_reg) + 12'h001;
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter did not step");
	property p_count_still;
		(!gs_rise && !blank_s) |=> $stable(cnt_reg);
	endproperty
	a_count_still: assert property (p_count_still) else $error("counter moved");
	property p_count_sat;
		(cnt_reg == `GSP_CNT_MAX && !blank_s) |=> cnt_reg == `GSP_CNT_MAX;
	endproperty
	a_count_sat: assert property (p_count_sat) else $error("counter wrapped");
	property p_blank_off;
		blank_s |=> sink_output_n_o == '0;
	endproperty
	a_blank_off: assert property (p_blank_off) else $error("output on in blank");
	property p_ch0_first;
		(!blank_s && !force_off_reg && !ovh_s && !auto_off_reg[0] && cnt_reg == 12'h001
			&& gs_lat_reg[11:0] != 12'h000) |=> sink_output_n_o[0];
	endproperty
	a_ch0_first: assert property (p_ch0_first) else $error("channel 0 not on");
	property p_ch0_above;
		(cnt_reg > gs_lat_reg[11:0]) |=> !sink_output_n_o[0];
	endproperty
	a_ch0_above: assert property (p_ch0_above) else $error("channel 0 on above value");
	property p_ch5_above;
		(cnt_reg > gs_lat_reg[71:60]) |=> !sink_output_n_o[5];
	endproperty
	a_ch5_above: assert property (p_ch5_above) else $error("channel 5 on above value");
	property p_current;
		sink_output_n_o[0] |-> sink_current_o[5:0] == $past(dc_lat_reg[5:0]);
	endproperty
	a_current: assert property (p_current) else $error("current code wrong");
	property p_auto_off;
		(sink_output_n_o[0] && open_s[0] && !blank_s) ##1 !blank_s |=> !sink_output_n_o[0];
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("open channel stayed on");
	property p_snap_load;
		(snap_pend_reg && sclk_rise && !correction_select_s)
			|=> gs_sr_reg[191:174] == $past(snapshot) && $stable(gs_sr_reg[173:0]);
	endproperty
	a_snap_load: assert property (p_snap_load) else $error("snapshot load wrong");
	property p_gs_shift;
		(sclk_rise && !correction_select_s && !snap_pend_reg)
			|=> gs_sr_reg == {$past(gs_sr_reg[190:0]), $past(sin_s)};
	endproperty
	a_gs_shift: assert property (p_gs_shift) else $error("grayscale shift wrong");
	property p_dc_latch;
		(strobe_rise && correction_select_s) |=> dc_lat_reg == $past(dc_sr_reg) && $stable(gs_lat_reg);
	endproperty
	a_dc_latch: assert property (p_dc_latch) else $error("correction latch wrong");
	property p_lod;
		(gs_rise && !blank_s && cnt_reg == 12'h020)
			|=> lod_saved_reg == $past(sink_output_n_o & open_s);
	endproperty
	a_lod: assert property (p_lod) else $error("open result not sampled");
	c_snap: cover property (snap_pend_reg && sclk_rise && !correction_select_s);
	c_full: cover property (cnt_reg == `GSP_CNT_MAX && sink_output_n_o[0]);
	c_auto: cover property (auto_off_reg[0] && !blank_s);
	c_irq: cover property (irq_o);

endmodule : gsp_pwm_driver

/* rtl/gsp_regs.svh */
`ifndef GSP_REGS_SVH
`define GSP_REGS_SVH

// ************************************************************
// channel and data widths
// ************************************************************
`define GSP_CH_N 16
`define GSP_CNT_W 12
`define GSP_CNT_MAX 12'hFFF
`define GSP_CNT_ONE 12'h001
`define GSP_DC_W 6
`define GSP_GS_SR_W 192
`define GSP_DC_SR_W 96
`define GSP_SNAP_W 18
`define GSP_SNAP_LSB 174
// open-led results are taken on the 33rd reference edge
`define GSP_LOD_SAMPLE_CNT 12'h021

// ************************************************************
// register byte offsets
// ************************************************************
`define GSP_ADR_CTRL 8'h00
`define GSP_ADR_STATUS 8'h04
`define GSP_ADR_MASK 8'h08
`define GSP_ADR_COUNT 8'h0C
`define GSP_ADR_SNAP 8'h10

// ************************************************************
// field positions and reset values
// ************************************************************
`define GSP_CTRL_FORCE_OFF 0
`define GSP_EV_LOD 0
`define GSP_EV_OVERHEAT 1
`define GSP_EV_SNAP 2
`define GSP_EV_WARN 3
`define GSP_RST_CTRL 1'h0
`define GSP_RST_MASK 4'h0

`endif

/* rtl/gsp_pkg.sv */
package gsp_pkg;
	typedef logic [11:0] gsp_count_t;
	typedef logic [15:0] gsp_chan_t;
	typedef logic [95:0] gsp_level_t;
	typedef logic [3:0] gsp_event_t;
	typedef logic [7:0] gsp_addr_t;
	typedef logic [31:0] gsp_word_t;
endpackage : gsp_pkg

/* tb/gsp_host_model.sv */
`timescale 1ns/100ps
// ****************
// host controller side of the serial link
// ****************
module gsp_host_model (
	// clock
	input wire logic clk_i,
	// answer from the driver
	input wire logic serial_output_i,
	// link pins
	output logic serial_input_o,
	output logic shift_clock_o,
	output logic latch_strobe_o,
	output logic correction_select_o,
	output logic blank_o,
	output logic pwm_reference_clock_o
);
	// blank stays high from power-up until both latches hold data
	initial begin
		serial_input_o = 1'b0;
		shift_clock_o = 1'b0;
		latch_strobe_o = 1'b0;
		correction_select_o = 1'b0;
		blank_o = 1'b1;
		pwm_reference_clock_o = 1'b0;
	end
	// half of an 800 ns link period, well over the 3-cycle sync need
	task hw();
		repeat (4) @(posedge clk_i);
	endtask : hw
	// one bit; the answer is sampled just before the shift edge
	task sbit(input logic b, output logic q);
		serial_input_o <= b;
		hw();
		q = serial_output_i;
		shift_clock_o <= 1'b1;
		hw();
		shift_clock_o <= 1'b0;
	endtask : sbit
	// grayscale word, msb first, read-back collected on the way
	task shift_gs(input logic [191:0] v, output logic [191:0] rd);
		logic q;
		for (int i = 191; i >= 0; i--) begin
			sbit(v[i], q);
			rd = {rd[190:0], q};
		end
		serial_input_o <= ~v[0]; // no pull: released line shows the inverse
	endtask : shift_gs
	// correction word, msb first
	task shift_dc(input logic [95:0] v);
		logic q;
		for (int i = 95; i >= 0; i--) begin
			sbit(v[i], q);
		end
		serial_input_o <= ~v[0];
	endtask : shift_dc
	// latch pulse
	task strobe();
		latch_strobe_o <= 1'b1;
		hw();
		latch_strobe_o <= 1'b0;
		hw();
	endtask : strobe
	// select and blanking levels
	task pins(input logic sel, input logic blk);
		correction_select_o <= sel;
		blank_o <= blk;
		hw();
	endtask : pins
	// reference clock runs only inside a burst
	task ref_pulse(input int n);
		repeat (n) begin
			pwm_reference_clock_o <= 1'b1;
			hw();
			pwm_reference_clock_o <= 1'b0;
			hw();
		end
	endtask : ref_pulse
endmodule : gsp_host_model

/* tb/grayscale_pwm_with_current_scaling_tb.sv */
`timescale 1ns/100ps
`include "gsp_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module grayscale_pwm_with_current_scaling_tb;
	import gsp_pkg::*;
	// ****************
	// data: ch0=1, ch1=3, ch2=0, ch3=all ones
	// ****************
	localparam logic [191:0] GS_V = {{12{12'h000}}, 12'hFFF, 12'h000, 12'h003, 12'h001};
	localparam logic [95:0] DC_V = {{12{6'h00}}, 6'h20, 6'h15, 6'h01, 6'h3F};
	typedef struct {int ed; gsp_count_t cnt; gsp_chan_t on;} gsp_row_t;
	gsp_row_t rows [5] = '{'{1, 12'h001, 16'h000B}, '{1, 12'h002, 16'h000A},
		'{1, 12'h003, 16'h000A}, '{1, 12'h004, 16'h0008}, '{28, 12'h020, 16'h0008}};
	// bench signals
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic serial_input, sck, stro, csel, blank, gref, serial_output, err_oe_n, err_pin, ack, irq, q;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic ovh = 1'b0;
	logic warn = 1'b0;
	logic [3:0] sel = 4'h0;
	gsp_chan_t open_det = 16'h0000;
	gsp_chan_t sink;
	gsp_level_t cur;
	gsp_addr_t adr = 8'h00;
	gsp_word_t wdat = 32'h0;
	gsp_word_t rdat, rd;
	logic [191:0] snap;
	int mismatches = 0;
	int comparisons = 0;
	// 100 ns clock
	always #50 clk_i = ~clk_i;
	// ****************
	// design and host
	// ****************
	gsp_pwm_driver dut_u (.clk_i(clk_i), .rst_i(rst_i), .serial_input_i(serial_input),
		.shift_clock_i(sck), .latch_strobe_i(stro), .correction_select_i(csel),
		.blank_i(blank), .pwm_reference_clock_i(gref), .serial_output_o(serial_output),
		.open_detect_i(open_det), .overheat_flag_i(ovh), .heat_warning_flag_i(warn),
		.sink_output_n_o(sink), .sink_current_o(cur), .error_indicator_pin_o(err_pin),
		.error_indicator_pin_oe_n_o(err_oe_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
	gsp_host_model host_u (.clk_i(clk_i), .serial_output_i(serial_output), .serial_input_o(serial_input),
		.shift_clock_o(sck), .latch_strobe_o(stro), .correction_select_o(csel),
		.blank_o(blank), .pwm_reference_clock_o(gref));
	// expected current: code while on, zero while off
	function automatic gsp_level_t cur_of(input gsp_chan_t on);
		gsp_level_t c;
		for (int i = 0; i < 16; i++) begin
			c[6*i +: 6] = on[i] ? DC_V[6*i +: 6] : 6'h00;
		end
		return c;
	endfunction : cur_of
	task clks(input int n);
		repeat (n) @(posedge clk_i);
	endtask : clks
	task done(input string s);
		$display("test %s finished", s);
	endtask : done
	// one classic cycle; the bound stops a dead slave
	task wb(input logic w, input gsp_addr_t a, input gsp_word_t d, input logic [3:0] s);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
		if (n >= 20) begin
			mismatches++;
			summarize();
		end
	endtask : wb
	task summarize();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	// ****************
	// main sequence
	// ****************
	initial begin
		clks(3);
		rst_i <= 1'b0;
		clks(3);
		host_u.pins(1'b1, 1'b1);
		host_u.shift_dc(DC_V);
		host_u.strobe();
		host_u.pins(1'b0, 1'b1);
		host_u.shift_gs(GS_V, snap);
		host_u.strobe();
		host_u.ref_pulse(3);
		wb(1'b0, `GSP_ADR_COUNT, 32'h0, 4'hF);
		`CHK("count", 32'h0, rd)
		`CHK("sink", 16'h0000, sink)
		done("blank");
		host_u.pins(1'b0, 1'b0);
		foreach (rows[i]) begin
			host_u.ref_pulse(rows[i].ed);
			wb(1'b0, `GSP_ADR_COUNT, 32'h0, 4'hF);
			`CHK("count", {20'h00000, rows[i].cnt}, rd)
			`CHK("sink", rows[i].on, sink)
			`CHK("current", cur_of(rows[i].on), cur)
		end
		done("pwm");
		// a write without its low byte lane is dropped
		wb(1'b1, `GSP_ADR_CTRL, 32'h1, 4'h0);
		wb(1'b0, `GSP_ADR_CTRL, 32'h0, 4'hF);
		`CHK("ctrl", 32'h0, rd)
		wb(1'b1, `GSP_ADR_CTRL, 32'h1, 4'hF);
		host_u.ref_pulse(1);
		`CHK("sink", 16'h0000, sink)
		wb(1'b1, `GSP_ADR_CTRL, 32'h0, 4'hF);
		host_u.ref_pulse(1);
		`CHK("sink", 16'h0008, sink)
		done("force_off");
		open_det <= 16'h0008;
		clks(6);
		`CHK("sink", 16'h0000, sink)
		open_det <= 16'h0000;
		host_u.ref_pulse(1);
		`CHK("sink", 16'h0000, sink)
		done("auto_off");
		warn <= 1'b1;
		clks(6);
		wb(1'b1, `GSP_ADR_MASK, 32'h8, 4'hF);
		`CHK("irq", 1'b1, irq)
		warn <= 1'b0;
		wb(1'b1, `GSP_ADR_STATUS, 32'h8, 4'hF);
		`CHK("irq", 1'b0, irq)
		`CHK("sink", 16'h0000, sink)
		done("irq");
		// counter must hold at all ones, not wrap
		host_u.ref_pulse(4062);
		wb(1'b0, `GSP_ADR_COUNT, 32'h0, 4'hF);
		`CHK("count", 32'hFFF, rd)
		host_u.pins(1'b0, 1'b1);
		host_u.ref_pulse(2);
		wb(1'b0, `GSP_ADR_COUNT, 32'h0, 4'hF);
		`CHK("count", 32'h0, rd)
		done("saturate");
		ovh <= 1'b1;
		clks(6);
		`CHK("err oe", 1'b0, err_oe_n)
		`CHK("err pin", 1'b0, err_pin)
		host_u.strobe();
		host_u.sbit(1'b0, q);
		host_u.shift_gs(192'h0, snap);
		`CHK("snapshot", {2'b11, 16'h0000, GS_V[173:0]}, snap)
		wb(1'b0, `GSP_ADR_SNAP, 32'h0, 4'hF);
		`CHK("snap reg", 32'h00030000, rd)
		// snapshot loads and the overheat rise are sticky; warning was cleared
		wb(1'b0, `GSP_ADR_STATUS, 32'h0, 4'hF);
		`CHK("status", 32'h00000006, rd)
		done("snapshot");
		ovh <= 1'b0;
		clks(6);
		host_u.pins(1'b0, 1'b0);
		host_u.ref_pulse(1);
		`CHK("sink", 16'h000B, sink)
		// open sense arrives with the 33rd reference edge while channel 3 is on
		host_u.ref_pulse(31);
		open_det <= 16'h0008;
		host_u.ref_pulse(1);
		open_det <= 16'h0000;
		wb(1'b0, `GSP_ADR_SNAP, 32'h0, 4'hF);
		`CHK("open bits", 32'h00000008, rd)
		`CHK("err oe", 1'b0, err_oe_n)
		rst_i <= 1'b1;
		clks(2);
		rst_i <= 1'b0;
		clks(3);
		`CHK("sink", 16'h0000, sink)
		`CHK("err oe", 1'b1, err_oe_n)
		`CHK("irq", 1'b0, irq)
		wb(1'b0, `GSP_ADR_MASK, 32'h0, 4'hF);
		`CHK("mask", 32'h0, rd)
		wb(1'b0, 8'h20, 32'h0, 4'hF);
		`CHK("unmapped", 32'h0, rd)
		done("reset");
		summarize();
	end
endmodule : grayscale_pwm_with_current_scaling_tb
